// ===== tec_params.svh
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses (low address byte)
// ----------------------------------------------------------------
`define TEC_ADDR_CTRL     8'h00
`define TEC_ADDR_COUNT    8'h04
`define TEC_ADDR_INTERRUPT_CONTROL     8'h08
`define TEC_ADDR_OPTION   8'h0C
`define TEC_ADDR_PORTB    8'h10

// ----------------------------------------------------------------
// counter_control fields
// ----------------------------------------------------------------
`define TEC_CTRL_PSC_LSB  0
`define TEC_CTRL_PSC_MSB  2
`define TEC_CTRL_EDGE     3
`define TEC_CTRL_RUN      4
`define TEC_CTRL_MODE_LSB 6
`define TEC_CTRL_MODE_MSB 7
`define TEC_CTRL_RESET    8'h08
`define TEC_CTRL_WMASK    8'hDF

// ----------------------------------------------------------------
// interrupt_control fields
// ----------------------------------------------------------------
`define TEC_INTERRUPT_CONTROL_IRQ_EN   0
`define TEC_INTERRUPT_CONTROL_FLAG     5
`define TEC_INTERRUPT_CONTROL_RESET    8'h00

// ----------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------
`define TEC_OPT_SLOW      0
`define TEC_OPT_RC_RTC    1
`define TEC_OPT_BZ0       2
`define TEC_OPT_BZ1       3
`define TEC_OPT_RESET     8'h00

// ----------------------------------------------------------------
// Port B register fields (direction bit 1 = input)
// ----------------------------------------------------------------
`define TEC_PB_LATCH0     0
`define TEC_PB_LATCH1     1
`define TEC_PB_PAD0       2
`define TEC_PB_PAD1       3
`define TEC_PB_DIR0       4
`define TEC_PB_DIR1       5
`define TEC_PB_RESET      8'h33
`define TEC_PB_WMASK      8'h33

// ----------------------------------------------------------------
// Counter constants
// ----------------------------------------------------------------
`define TEC_CNT_MAX       8'hFF
`define TEC_CNT_RESET     8'h00
`define TEC_DIV_RESET     8'h00

`endif

// ===== tec_pkg.sv
package tec_pkg;

	typedef enum logic [1:0] {
		TEC_MODE_UNUSED = 2'h0,
		TEC_MODE_EVENT  = 2'h1,
		TEC_MODE_TIMER  = 2'h2,
		TEC_MODE_PULSE  = 2'h3
	} tec_mode_t;

	typedef enum logic [2:0] {
		TEC_PW_IDLE    = 3'h1,
		TEC_PW_ARMED   = 3'h2,
		TEC_PW_MEASURE = 3'h4
	} tec_pw_state_t;

endpackage : tec_pkg

// ===== tec_tick_if.sv
interface tec_tick_if;
	logic       src_slow;
	logic [2:0] prescale_select;
	logic       tick;

	modport provider (
		input  src_slow,
		input  prescale_select,
		output tick
	);

	modport user (
		output src_slow,
		output prescale_select,
		input  tick
	);
endinterface : tec_tick_if

// ===== tec_prescaler.sv
`include "tec_params.svh"

module tec_prescaler (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Slow crystal clock, asynchronous to sys_clk
	input  wire logic        slow_clk,
	// Tick carrier
	tec_tick_if.provider     tk
);

	// ----------------------------------------------------------------
	// Slow clock synchroniser and edge detect
	// ----------------------------------------------------------------
	logic       slow_s1;
	logic       slow_s2;
	logic       slow_d;
	logic       src_tick;
	logic [7:0] div_cnt;
	logic [7:0] mask;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
			slow_d  <= 1'b0;
		end else begin
			slow_s1 <= slow_clk;
			slow_s2 <= slow_s1;
			slow_d  <= slow_s2;
		end
	end

	assign src_tick = tk.src_slow ? (slow_s2 & ~slow_d) : 1'b1;

	// ----------------------------------------------------------------
	// Divide by two to the power of (code plus one)
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_mask
			assign mask[i] = (3'(i) <= tk.prescale_select);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= `TEC_DIV_RESET;
		end else if (src_tick) begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// One sys_clk pulse per divided period
	assign tk.tick = src_tick && ((div_cnt & mask) == mask);

endmodule : tec_prescaler

// ===== tec_counter.sv
// Added by the designer: the AHB-Lite slave port and the address map.
`include "tec_params.svh"

module tec_counter (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// External count pin and slow crystal clock
	input  wire logic        count_pin,
	input  wire logic        slow_clk,
	// Port B pins zero and one
	input  wire logic        port_b_pin_zero_i,
	output logic             port_b_pin_zero_o,
	output logic             port_b_pin_zero_oe,
	input  wire logic        port_b_pin_one_i,
	output logic             port_b_pin_one_o,
	output logic             port_b_pin_one_oe,
	// Events to the rest of the chip
	output logic             irq_request,
	output logic             wake_event,
	output logic             tone_signal
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0]                 counter_control;
	logic [7:0]                 interrupt_control;
	logic [7:0]                 option_reg;
	logic [7:0]                 port_b_reg;
	logic [7:0]                 event_counter;
	logic [7:0]                 preload;
	tec_pkg::tec_pw_state_t     pw_state;
	tec_pkg::tec_pw_state_t     next_pw_state;
	tec_pkg::tec_mode_t         mode;

	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        accept;
	logic        rd_accept;
	logic        read_block;
	logic [7:0]  wdata;
	logic        wr_ctrl;
	logic        wr_count;
	logic        wr_interrupt_control;
	logic        wr_opt;
	logic        wr_pb;
	logic [7:0]  rd_value;

	logic        pin_s1;
	logic        pin_s2;
	logic        pin_d;
	logic        pin_rise;
	logic        pin_fall;
	logic        act_edge;
	logic        ret_edge;
	logic        pb0_s1;
	logic        pb0_s2;
	logic        pb1_s1;
	logic        pb1_s2;

	logic        run;
	logic        count_tick;
	logic        overflow;
	logic        pw_done;

	tec_tick_if  tk ();

	assign run  = counter_control[`TEC_CTRL_RUN];
	assign mode = tec_pkg::tec_mode_t'(counter_control[`TEC_CTRL_MODE_MSB:`TEC_CTRL_MODE_LSB]);

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	// Zero wait states; every transfer answers OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign accept    = hsel && htrans[1] && hready;
	assign rd_accept = accept && !hwrite;
	assign wdata     = hwdata[7:0];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= accept && hwrite;
			if (accept) begin
				wr_addr <= haddr[7:0];
			end
		end
	end

	assign wr_ctrl  = wr_pend && (wr_addr == `TEC_ADDR_CTRL);
	assign wr_count = wr_pend && (wr_addr == `TEC_ADDR_COUNT);
	assign wr_interrupt_control  = wr_pend && (wr_addr == `TEC_ADDR_INTERRUPT_CONTROL);
	assign wr_opt   = wr_pend && (wr_addr == `TEC_ADDR_OPTION);
	assign wr_pb    = wr_pend && (wr_addr == `TEC_ADDR_PORTB);

	// Lost ticks during the blocked cycle are accepted by design
	assign read_block = rd_accept && (haddr[7:0] == `TEC_ADDR_COUNT);

	always_comb begin
		rd_value = 8'h00;
		if (haddr[7:0] == `TEC_ADDR_CTRL) begin
			rd_value = counter_control & `TEC_CTRL_WMASK;
		end else if (haddr[7:0] == `TEC_ADDR_COUNT) begin
			rd_value = event_counter;
		end else if (haddr[7:0] == `TEC_ADDR_INTERRUPT_CONTROL) begin
			rd_value = interrupt_control;
		end else if (haddr[7:0] == `TEC_ADDR_OPTION) begin
			rd_value = option_reg;
		end else if (haddr[7:0] == `TEC_ADDR_PORTB) begin
			rd_value = port_b_reg;
			rd_value[`TEC_PB_PAD0] = pb0_s2;
			rd_value[`TEC_PB_PAD1] = pb1_s2;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_accept) begin
			hrdata <= {24'h00_0000, rd_value};
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_d  <= 1'b0;
			pb0_s1 <= 1'b0;
			pb0_s2 <= 1'b0;
			pb1_s1 <= 1'b0;
			pb1_s2 <= 1'b0;
		end else begin
			pin_s1 <= count_pin;
			pin_s2 <= pin_s1;
			pin_d  <= pin_s2;
			pb0_s1 <= port_b_pin_zero_i;
			pb0_s2 <= pb0_s1;
			pb1_s1 <= port_b_pin_one_i;
			pb1_s2 <= pb1_s1;
		end
	end

	assign pin_rise = pin_s2 & ~pin_d;
	assign pin_fall = ~pin_s2 & pin_d;
	assign act_edge = counter_control[`TEC_CTRL_EDGE] ? pin_fall : pin_rise;
	assign ret_edge = counter_control[`TEC_CTRL_EDGE] ? pin_rise : pin_fall;

	// ----------------------------------------------------------------
	// Internal time base
	// ----------------------------------------------------------------
	// Slow crystal only counts when the oscillator option allows it
	assign tk.src_slow = option_reg[`TEC_OPT_SLOW] & option_reg[`TEC_OPT_RC_RTC];
	assign tk.prescale_select = counter_control[`TEC_CTRL_PSC_MSB:`TEC_CTRL_PSC_LSB];

	tec_prescaler u_prescaler (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.slow_clk (slow_clk),
		.tk       (tk.provider)
	);

	// ----------------------------------------------------------------
	// Pulse width sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_pw_state = pw_state;
		case (pw_state)
			tec_pkg::TEC_PW_IDLE: begin
				if (run && mode == tec_pkg::TEC_MODE_PULSE) begin
					next_pw_state = tec_pkg::TEC_PW_ARMED;
				end
			end
			tec_pkg::TEC_PW_ARMED: begin
				if (!run || mode != tec_pkg::TEC_MODE_PULSE) begin
					next_pw_state = tec_pkg::TEC_PW_IDLE;
				end else if (act_edge) begin
					next_pw_state = tec_pkg::TEC_PW_MEASURE;
				end
			end
			tec_pkg::TEC_PW_MEASURE: begin
				if (!run || mode != tec_pkg::TEC_MODE_PULSE || ret_edge) begin
					next_pw_state = tec_pkg::TEC_PW_IDLE;
				end
			end
			default: begin
				next_pw_state = tec_pkg::TEC_PW_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pw_state <= tec_pkg::TEC_PW_IDLE;
		end else begin
			pw_state <= next_pw_state;
		end
	end

	assign pw_done = (pw_state == tec_pkg::TEC_PW_MEASURE) && run && ret_edge
		&& (mode == tec_pkg::TEC_MODE_PULSE);

	// ----------------------------------------------------------------
	// Count clock selection
	// ----------------------------------------------------------------
	always_comb begin
		count_tick = 1'b0;
		case (mode)
			tec_pkg::TEC_MODE_EVENT: count_tick = act_edge;
			tec_pkg::TEC_MODE_TIMER: count_tick = tk.tick;
			tec_pkg::TEC_MODE_PULSE: count_tick = tk.tick
				&& (pw_state == tec_pkg::TEC_PW_MEASURE) && !ret_edge;
			default: count_tick = 1'b0;
		endcase
		count_tick = count_tick && run && !read_block;
	end

	assign overflow = count_tick && (event_counter == `TEC_CNT_MAX);

	// ----------------------------------------------------------------
	// Counter and preload
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			preload <= `TEC_CNT_RESET;
		end else if (wr_count) begin
			preload <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_counter <= `TEC_CNT_RESET;
		end else if (wr_count && !run) begin
			event_counter <= wdata;
		end else if (overflow) begin
			event_counter <= preload;
		end else if (count_tick) begin
			event_counter <= event_counter + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// A software write in the same cycle as the end of a measurement wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_control <= `TEC_CTRL_RESET;
		end else if (wr_ctrl) begin
			counter_control <= wdata & `TEC_CTRL_WMASK;
		end else if (pw_done) begin
			counter_control[`TEC_CTRL_RUN] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Request flag, enable, wake-up
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_control <= `TEC_INTERRUPT_CONTROL_RESET;
		end else begin
			if (wr_interrupt_control) begin
				interrupt_control <= wdata;
			end
			// Set beats a simultaneous software clear
			if (overflow) begin
				interrupt_control[`TEC_INTERRUPT_CONTROL_FLAG] <= 1'b1;
			end
		end
	end

	assign irq_request = interrupt_control[`TEC_INTERRUPT_CONTROL_FLAG]
		& interrupt_control[`TEC_INTERRUPT_CONTROL_IRQ_EN];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_event <= 1'b0;
		end else begin
			wake_event <= overflow;
		end
	end

	// ----------------------------------------------------------------
	// Tone generator and option register
	// ----------------------------------------------------------------
	// Toggling halves the overflow rate but gives a clean 50% duty tone
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tone_signal <= 1'b0;
		end else if (overflow) begin
			tone_signal <= ~tone_signal;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			option_reg <= `TEC_OPT_RESET;
		end else if (wr_opt) begin
			option_reg <= wdata;
		end
	end

	// ----------------------------------------------------------------
	// Port B pins zero and one
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_b_reg <= `TEC_PB_RESET;
		end else if (wr_pb) begin
			port_b_reg <= wdata & `TEC_PB_WMASK;
		end
	end

	// Inputs keep their plain function; buzzer only affects driven pads
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_b_pin_zero_o  <= 1'b0;
			port_b_pin_zero_oe <= 1'b0;
			port_b_pin_one_o   <= 1'b0;
			port_b_pin_one_oe  <= 1'b0;
		end else begin
			port_b_pin_zero_oe <= ~port_b_reg[`TEC_PB_DIR0];
			port_b_pin_one_oe  <= ~port_b_reg[`TEC_PB_DIR1];
			if (option_reg[`TEC_OPT_BZ0]) begin
				port_b_pin_zero_o <= port_b_reg[`TEC_PB_LATCH0] & tone_signal;
			end else begin
				port_b_pin_zero_o <= port_b_reg[`TEC_PB_LATCH0];
			end
			if (option_reg[`TEC_OPT_BZ1]) begin
				port_b_pin_one_o <= port_b_reg[`TEC_PB_LATCH0] & ~tone_signal;
			end else begin
				port_b_pin_one_o <= port_b_reg[`TEC_PB_LATCH1];
			end
		end
	end

	logic unused_ok;
	assign unused_ok = ^{haddr[31:8], hsize, hwdata[31:8]};

endmodule : tec_counter

// ===== tec_counter_checker.sv
module tec_counter_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Register bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// Events
	input wire logic        irq_request,
	input wire logic        wake_event,
	input wire logic        tone_signal
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic taken;
	logic rd_any;
	logic rd_ctrl;
	logic rd_unmap;
	logic wr_interrupt_control;
	assign taken = hsel & htrans[1] & hready;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_any   <= 1'b0;
			rd_ctrl  <= 1'b0;
			rd_unmap <= 1'b0;
			wr_interrupt_control  <= 1'b0;
		end else begin
			rd_any   <= taken & !hwrite;
			rd_ctrl  <= taken & !hwrite & (haddr[7:0] == 8'h00);
			rd_unmap <= taken & !hwrite & (haddr[7:0] > 8'h10);
			wr_interrupt_control  <= taken & hwrite & (haddr[7:0] == 8'h08);
		end
	end
	sequence s_overflow;
		$changed(tone_signal);
	endsequence
	a_bus_okay_ready: assert property (hreadyout && !hresp)
		else $error("bus response not ready/okay");
	a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_ctrl_bit_five: assert property (rd_ctrl |-> !hrdata[5])
		else $error("control bit five read as one");
	a_unmapped_zero: assert property (rd_unmap |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property ($changed(hrdata) |-> rd_any)
		else $error("read data changed without a read");
	// Tone and wake both leave the overflow edge, so they are seen together
	a_wake_follows: assert property (s_overflow |-> wake_event)
		else $error("no wake pulse after overflow");
	a_wake_cause: assert property (wake_event |-> s_overflow)
		else $error("wake pulse without overflow");
	a_tone_spacing: assert property (s_overflow |=> $stable(tone_signal))
		else $error("tone toggled on consecutive cycles");
	a_irq_rise_cause: assert property ($rose(irq_request) |-> $changed(tone_signal) || $past(wr_interrupt_control))
		else $error("interrupt rose without overflow or write");
	a_irq_fall_cause: assert property ($fell(irq_request) |-> $past(wr_interrupt_control))
		else $error("interrupt fell without software write");
endmodule : tec_counter_checker

bind tec_counter tec_counter_checker tec_counter_checker_inst (.sys_clk, .rst_n, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .irq_request, .wake_event,
	.tone_signal);

// ===== tec_pin_source.sv
module tec_pin_source (
	// Pacing clock
	input  wire logic sys_clk,
	// Count pin and slow crystal clock
	output logic      count_pin,
	output logic      slow_clk,
	// Port B pads
	input  wire logic pin0_o,
	input  wire logic pin0_oe,
	input  wire logic pin1_o,
	input  wire logic pin1_oe,
	output logic      pad0,
	output logic      pad1
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		count_pin = 1'b0;
		slow_clk  = 1'b0;
	end
	// Crystal runs free; its edges fall between system clock rising edges
	always #40 slow_clk = ~slow_clk;
	// Released pads float up through the pull-high
	assign pad0 = pin0_oe ? pin0_o : 1'b1;
	assign pad1 = pin1_oe ? pin1_o : 1'b1;
	// Level held whole cycles; callers never go below two
	task automatic drive(input logic lvl, input int n);
		count_pin <= lvl;
		repeat (n) @(posedge sys_clk);
	endtask : drive
endmodule : tec_pin_source

// ===== tb_top.sv
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rst_n, hsel, hwrite, count_pin, slow_clk, pad0, pad1;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [7:0]  rd, v;
	wire logic        hready, hresp, irq_request, wake_event, tone_signal;
	wire logic        p0_o, p0_oe, p1_o, p1_oe;
	wire logic [31:0] hrdata;
	int          error_cnt, compares, cycles, c;
	tec_counter tec_counter_inst (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .count_pin,
		.slow_clk, .port_b_pin_zero_i(pad0), .port_b_pin_zero_o(p0_o),
		.port_b_pin_zero_oe(p0_oe), .port_b_pin_one_i(pad1), .port_b_pin_one_o(p1_o),
		.port_b_pin_one_oe(p1_oe), .irq_request, .wake_event, .tone_signal);
	tec_pin_source tec_pin_source_inst (.sys_clk, .count_pin, .slow_clk, .pin0_o(p0_o),
		.pin0_oe(p0_oe), .pin1_o(p1_o), .pin1_oe(p1_oe), .pad0, .pad1);
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	// ----------------------------------------------------------------
	// Bus master and helpers
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask : xfer
	task automatic chk(input logic [7:0] a, input logic [7:0] e, input string nm);
		xfer(a, 1'b0, 8'h00);
		`CHK(nm, e, rd)
	endtask : chk
	// Counts negedges until the tone changes, then realigns to a rising edge
	task automatic wait_tone();
		logic t;
		t = tone_signal;
		c = 0;
		while (tone_signal === t && c < 3000) begin
			@(negedge sys_clk);
			c++;
		end
		@(posedge sys_clk);
	endtask : wait_tone
	task automatic period(input logic [7:0] ctl, input int e);
		xfer(8'h00, 1'b1, ctl);
		wait_tone();
		wait_tone();
		`CHK("overflow_period", e, c)
	endtask : period
	task automatic bz(input logic [7:0] opt, input logic [7:0] pb, input logic [3:0] e);
		xfer(8'h0C, 1'b1, opt);
		xfer(8'h10, 1'b1, pb);
		repeat (2) @(posedge sys_clk);
		`CHK("buzzer_pins", e, {p1_oe, p1_o, p0_oe, p0_o})
	endtask : bz
	task automatic done(input string nm);
		$display("[DONE] %s errors %0d compares %0d", nm, error_cnt, compares);
	endtask : done
	task automatic report_and_stop();
		$display("Counts: errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// Whole run needs well under ten thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk(8'h00, 8'h08, "ctrl_reset");
		chk(8'h04, 8'h00, "count_reset");
		chk(8'h08, 8'h00, "interrupt_control_reset");
		xfer(8'h00, 1'b1, 8'hFF);
		chk(8'h00, 8'hDF, "ctrl_bit5");
		xfer(8'h40, 1'b1, 8'hFF);
		chk(8'h40, 8'h00, "unmapped");
		done("registers");
		xfer(8'h00, 1'b1, 8'h80);
		xfer(8'h04, 1'b1, 8'hFF);
		for (int k = 0; k < 8; k++)
			period(8'h90 | 8'(k), 2 << k);
		chk(8'h00, 8'h97, "run_kept");
		chk(8'h08, 8'h20, "flag_set");
		`CHK("irq_masked", 1'b0, irq_request)
		xfer(8'h0C, 1'b1, 8'h03);
		period(8'h90, 16);
		xfer(8'h0C, 1'b1, 8'h01);
		period(8'h90, 2);
		done("timer_divider");
		xfer(8'h00, 1'b1, 8'h87);
		xfer(8'h04, 1'b1, 8'hFE);
		chk(8'h04, 8'hFE, "count_load");
		xfer(8'h08, 1'b1, 8'h00);
		xfer(8'h08, 1'b1, 8'h01);
		xfer(8'h00, 1'b1, 8'h97);
		xfer(8'h04, 1'b1, 8'h10);
		xfer(8'h04, 1'b0, 8'h00);
		`CHK("count_kept", 1'b1, rd != 8'h10)
		wait_tone();
		chk(8'h04, 8'h10, "count_reload");
		`CHK("irq_raised", 1'b1, irq_request)
		chk(8'h08, 8'h21, "interrupt_control_flag");
		bz(8'h0C, 8'h01, {1'b1, ~tone_signal, 1'b1, tone_signal});
		bz(8'h0C, 8'h00, 4'hA);
		bz(8'h04, 8'h03, {3'b111, tone_signal});
		bz(8'h04, 8'h30, 4'h0);
		xfer(8'h00, 1'b1, 8'h87);
		xfer(8'h04, 1'b0, 8'h00);
		v = rd;
		repeat (600) @(posedge sys_clk);
		chk(8'h04, v, "count_held");
		xfer(8'h00, 1'b1, 8'h10);
		repeat (20) @(posedge sys_clk);
		chk(8'h04, v, "unused_mode");
		xfer(8'h08, 1'b1, 8'h00);
		// The clear lands on the edge the task returns at; look one edge later
		@(posedge sys_clk);
		`CHK("irq_cleared", 1'b0, irq_request)
		done("preload_buzzer");
		for (int e = 0; e < 2; e++) begin
			xfer(8'h00, 1'b1, 8'h40 | 8'(e << 3));
			xfer(8'h04, 1'b1, 8'h00);
			xfer(8'h00, 1'b1, 8'h50 | 8'(e << 3));
			tec_pin_source_inst.drive(1'b1, 6);
			chk(8'h04, 8'(1 - e), "event_rise");
			tec_pin_source_inst.drive(1'b0, 6);
			chk(8'h04, 8'h01, "event_fall");
		end
		done("event_count");
		xfer(8'h00, 1'b1, 8'hC0);
		xfer(8'h04, 1'b1, 8'h00);
		xfer(8'h00, 1'b1, 8'hD0);
		tec_pin_source_inst.drive(1'b1, 40);
		tec_pin_source_inst.drive(1'b0, 6);
		chk(8'h00, 8'hC0, "pulse_run_clear");
		xfer(8'h04, 1'b0, 8'h00);
		v = rd;
		`CHK("pulse_width", 1'b1, v >= 8'h13 && v <= 8'h15)
		tec_pin_source_inst.drive(1'b1, 40);
		tec_pin_source_inst.drive(1'b0, 6);
		chk(8'h04, v, "pulse_single");
		xfer(8'h04, 1'b1, 8'hFE);
		xfer(8'h00, 1'b1, 8'hD0);
		tec_pin_source_inst.drive(1'b1, 40);
		tec_pin_source_inst.drive(1'b0, 6);
		chk(8'h08, 8'h20, "pulse_overflow");
		done("pulse_width");
		report_and_stop();
	end
endmodule : tb_top
